/* File: upc_pkg.sv */
// register map, field layout and timing constants of the user and power control bank
package upc_pkg;

  // register offsets
  localparam logic [7:0] UPC_OFS_USER_CONTROL = 8'h6A;
  localparam logic [7:0] UPC_OFS_POWER_ONE    = 8'h6B;
  localparam logic [7:0] UPC_OFS_POWER_TWO    = 8'h6C;

  // user control fields
  localparam int UPC_UC_QUEUE_EN      = 6;
  localparam int UPC_UC_AUX_MST_EN    = 5;
  localparam int UPC_UC_PRI_IF_DIS    = 4;
  localparam int UPC_UC_QUEUE_RST     = 2;
  localparam int UPC_UC_AUX_MST_RST   = 1;
  localparam int UPC_UC_SENSOR_RST    = 0;
  localparam logic [7:0] UPC_UC_WMASK = 8'h77;

  // power control one fields
  localparam int UPC_P1_DEV_RESET     = 7;
  localparam int UPC_P1_SLEEP         = 6;
  localparam int UPC_P1_CYCLE         = 5;
  localparam int UPC_P1_THERMO_OFF    = 3;
  localparam int UPC_P1_CLOCK_SOURCE_SELECT_LSB    = 0;
  localparam logic [7:0] UPC_P1_WMASK = 8'hEF;

  // power control two fields
  localparam int UPC_P2_WAKE_LSB      = 6;
  localparam int UPC_P2_GYRO_Z_STBY   = 0;

  // reset values
  localparam logic [7:0] UPC_UC_RESET = 8'h00;
  localparam logic [7:0] UPC_P1_RESET = 8'h00;
  localparam logic [7:0] UPC_P2_RESET = 8'h00;

  // clock source codes
  typedef enum logic [2:0] {
    UPC_CLK_INTERNAL = 3'h0,
    UPC_CLK_GYRO_X   = 3'h1,
    UPC_CLK_GYRO_Y   = 3'h2,
    UPC_CLK_GYRO_Z   = 3'h3,
    UPC_CLK_EXT_32K  = 3'h4,
    UPC_CLK_EXT_19M  = 3'h5,
    UPC_CLK_RESERVED = 3'h6,
    UPC_CLK_STOPPED  = 3'h7
  } upc_clksrc_type;

  // timing: device reset pulse length and wake periods
  localparam int UPC_CLK_HZ            = 200_000_000;
  localparam int UPC_DEV_RESET_NS      = 100;
  // scaled to kHz first so the product stays inside a 32-bit int
  localparam int UPC_DEV_RESET_CYCLES  = (UPC_DEV_RESET_NS * (UPC_CLK_HZ / 1000)
                                          + 999_999) / 1_000_000;
  localparam int UPC_WAKE_MS_0_X100    = 80000;
  localparam int UPC_WAKE_MS_1         = 200;
  localparam int UPC_WAKE_MS_2         = 50;
  localparam int UPC_WAKE_MS_3         = 25;
  localparam int UPC_WAKE_CYCLES_0     = UPC_WAKE_MS_0_X100 / 100 * (UPC_CLK_HZ / 1000);
  localparam int UPC_WAKE_CYCLES_1     = UPC_WAKE_MS_1 * (UPC_CLK_HZ / 1000);
  localparam int UPC_WAKE_CYCLES_2     = UPC_WAKE_MS_2 * (UPC_CLK_HZ / 1000);
  localparam int UPC_WAKE_CYCLES_3     = UPC_WAKE_MS_3 * (UPC_CLK_HZ / 1000);
  localparam int UPC_SAMPLE_CYCLES     = 4;

endpackage : upc_pkg

/* File: upc_wake_timer.sv */
// periodic wake timer for cycle mode
`timescale 1ns/1ps
module upc_wake_timer
  import upc_pkg::*;
#(
  parameter int WAKE_CYCLES_0 = UPC_WAKE_CYCLES_0,
  parameter int WAKE_CYCLES_1 = UPC_WAKE_CYCLES_1,
  parameter int WAKE_CYCLES_2 = UPC_WAKE_CYCLES_2,
  parameter int WAKE_CYCLES_3 = UPC_WAKE_CYCLES_3
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // control
  input  wire logic       run,
  input  wire logic [1:0] rateSel,
  // wake pulse
  output logic            wakeTick
);

  logic [31:0] count_reg;
  logic [31:0] period;

  function automatic logic [31:0] period_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: period_of = 32'(WAKE_CYCLES_0);
      2'h1: period_of = 32'(WAKE_CYCLES_1);
      2'h2: period_of = 32'(WAKE_CYCLES_2);
      2'h3: period_of = 32'(WAKE_CYCLES_3);
    endcase
  endfunction : period_of

  assign period = period_of(rateSel);

  // counter restarts whenever cycle mode is left so each entry begins a full period
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 32'h0;
      wakeTick  <= 1'b0;
    end else if (!run) begin
      count_reg <= 32'h0;
      wakeTick  <= 1'b0;
    end else if (count_reg >= period - 32'h1) begin
      count_reg <= 32'h0;
      wakeTick  <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h1;
      wakeTick  <= 1'b0;
    end
  end

endmodule : upc_wake_timer

/* File: upc_regs.sv */
// user control and power management register bank
`timescale 1ns/1ps

module upc_regs
  import upc_pkg::*;
#(
  parameter bit SPI_CAPABLE   = 1'b1,
  parameter int WAKE_CYCLES_0 = UPC_WAKE_CYCLES_0,
  parameter int WAKE_CYCLES_1 = UPC_WAKE_CYCLES_1,
  parameter int WAKE_CYCLES_2 = UPC_WAKE_CYCLES_2,
  parameter int WAKE_CYCLES_3 = UPC_WAKE_CYCLES_3
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // register port from the primary serial interface
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWdata,
  input  wire logic       regRead,
  output logic [7:0]      regRdata,
  // sample queue
  input  wire logic       queuePushReq,
  input  wire logic       queuePopReq,
  output logic            queuePushOk,
  output logic            queuePopOk,
  output logic            queueReinit,
  // auxiliary bus: primary bus pins (already synchronised) and master engine
  input  wire logic       priSdaIn,
  input  wire logic       priSclIn,
  input  wire logic       mstSdaOut,
  input  wire logic       mstSclOut,
  output logic            auxMasterActive,
  output logic            auxMasterReinit,
  output logic            auxDataOut,
  output logic            auxDataOe,
  output logic            auxClockOut,
  output logic            auxClockOe,
  // primary interface select
  output logic            spiSelect,
  // sensor paths
  output logic            sensorPathReinit,
  output logic            sensorResultClear,
  output logic [2:0]      accelStandby,
  output logic [2:0]      gyroStandby,
  output logic            thermoOff,
  output logic            accelSampleReq,
  // power and clock
  output logic            sleepMode,
  output logic            lowPowerAccelOnly,
  output logic            deviceReset,
  output logic [2:0]      clockSourceSel,
  output logic            clockStopped
);

  // reset sequencer states
  typedef enum logic [1:0] {
    UPC_DEV_IDLE  = 2'b01,
    UPC_DEV_RESET = 2'b10
  } upc_devstate_type;

  logic [7:0]       userCtrl_reg;
  logic [7:0]       powerOne_reg;
  logic [7:0]       powerTwo_reg;
  upc_devstate_type devState_reg;
  logic [7:0]       devCount_reg;
  logic [2:0]       clock_source_select_reg;
  logic             sampleReq_reg;
  logic             wrUser;
  logic             wrPowerOne;
  logic             wrPowerTwo;
  logic             softReset;
  logic             cycleRun;
  logic             wakeTick;
  logic [2:0]       effClk;

  assign wrUser     = regWrite && (regAddr == UPC_OFS_USER_CONTROL);
  assign wrPowerOne = regWrite && (regAddr == UPC_OFS_POWER_ONE);
  assign wrPowerTwo = regWrite && (regAddr == UPC_OFS_POWER_TWO);
  assign softReset  = (devState_reg == UPC_DEV_RESET);

  // gyro-referenced source whose axis is in standby falls back to internal
  function automatic logic [2:0] eff_clock(input logic [2:0] sel, input logic [2:0] gstby);
    logic [2:0] res;
    res = sel;
    if ((sel == UPC_CLK_GYRO_X && gstby[2]) ||
        (sel == UPC_CLK_GYRO_Y && gstby[1]) ||
        (sel == UPC_CLK_GYRO_Z && gstby[0]))
      res = UPC_CLK_INTERNAL;
    eff_clock = res;
  endfunction : eff_clock

  // user control: self clearing reset bits never store, so they read zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      userCtrl_reg <= UPC_UC_RESET;
    end else if (softReset) begin
      userCtrl_reg <= UPC_UC_RESET;
    end else if (wrUser) begin
      userCtrl_reg <= regWdata & UPC_UC_WMASK & 8'h70;
      if (!SPI_CAPABLE)
        userCtrl_reg[UPC_UC_PRI_IF_DIS] <= 1'b0;
    end
  end

  // reset pulses: queue and aux master pulse one cycle, only when their enable is low; sensor path is ungated and held through device reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      queueReinit      <= 1'b0;
      auxMasterReinit  <= 1'b0;
      sensorPathReinit <= 1'b0;
    end else begin
      queueReinit      <= wrUser && regWdata[UPC_UC_QUEUE_RST]
                          && !userCtrl_reg[UPC_UC_QUEUE_EN];
      auxMasterReinit  <= wrUser && regWdata[UPC_UC_AUX_MST_RST]
                          && !userCtrl_reg[UPC_UC_AUX_MST_EN];
      sensorPathReinit <= (wrUser && regWdata[UPC_UC_SENSOR_RST]) || softReset;
    end
  end

  assign sensorResultClear = sensorPathReinit;

  // power one: device reset bit handled by the sequencer, reads as its state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      powerOne_reg <= UPC_P1_RESET;
    end else if (softReset) begin
      powerOne_reg <= UPC_P1_RESET;
    end else if (wrPowerOne) begin
      powerOne_reg <= regWdata & UPC_P1_WMASK & 8'h6F;
    end
  end

  // power two
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      powerTwo_reg <= UPC_P2_RESET;
    end else if (softReset) begin
      powerTwo_reg <= UPC_P2_RESET;
    end else if (wrPowerTwo) begin
      powerTwo_reg <= regWdata;
    end
  end

  // whole-device reset sequencer; bit reads one until the pulse completes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      devState_reg <= UPC_DEV_IDLE;
      devCount_reg <= 8'h0;
    end else begin
      unique case (devState_reg)
        UPC_DEV_IDLE: begin
          if (wrPowerOne && regWdata[UPC_P1_DEV_RESET]) begin
            devState_reg <= UPC_DEV_RESET;
            devCount_reg <= 8'(UPC_DEV_RESET_CYCLES - 1);
          end
        end
        UPC_DEV_RESET: begin
          if (devCount_reg == 8'h0)
            devState_reg <= UPC_DEV_IDLE;
          else
            devCount_reg <= devCount_reg - 8'h1;
        end
        default: devState_reg <= UPC_DEV_IDLE;
      endcase
    end
  end

  assign deviceReset = softReset;

  // effective clock source, registered so glitches never reach the clock mux
  assign effClk = eff_clock(powerOne_reg[UPC_P1_CLOCK_SOURCE_SELECT_LSB +: 3], powerTwo_reg[2:0]);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clock_source_select_reg <= UPC_CLK_INTERNAL;
    end else begin
      clock_source_select_reg <= effClk;
    end
  end

  assign clockSourceSel = clock_source_select_reg;
  assign clockStopped   = (clock_source_select_reg == UPC_CLK_STOPPED);

  // cycle mode wake timer
  assign cycleRun = powerOne_reg[UPC_P1_CYCLE] && !powerOne_reg[UPC_P1_SLEEP];

  upc_wake_timer #(
    .WAKE_CYCLES_0 (WAKE_CYCLES_0),
    .WAKE_CYCLES_1 (WAKE_CYCLES_1),
    .WAKE_CYCLES_2 (WAKE_CYCLES_2),
    .WAKE_CYCLES_3 (WAKE_CYCLES_3)
  ) u_wake (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .run      (cycleRun),
    .rateSel  (powerTwo_reg[UPC_P2_WAKE_LSB +: 2]),
    .wakeTick (wakeTick)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sampleReq_reg <= 1'b0;
    end else begin
      // a tick launched as cycle mode ends must not leak out one cycle late
      sampleReq_reg <= wakeTick && cycleRun;
    end
  end

  assign accelSampleReq = sampleReq_reg;

  // power outputs
  assign sleepMode         = powerOne_reg[UPC_P1_SLEEP] || cycleRun;
  assign thermoOff         = powerOne_reg[UPC_P1_THERMO_OFF] || powerOne_reg[UPC_P1_SLEEP];
  assign accelStandby      = powerTwo_reg[5:3];
  assign gyroStandby       = powerTwo_reg[2:0];
  assign lowPowerAccelOnly = cycleRun && powerOne_reg[UPC_P1_THERMO_OFF]
                             && (&powerTwo_reg[2:0]);

  // queue gating
  assign queuePushOk = queuePushReq && userCtrl_reg[UPC_UC_QUEUE_EN];
  assign queuePopOk  = queuePopReq && userCtrl_reg[UPC_UC_QUEUE_EN];

  // interface select and aux bus routing
  assign spiSelect       = SPI_CAPABLE && userCtrl_reg[UPC_UC_PRI_IF_DIS];
  assign auxMasterActive = userCtrl_reg[UPC_UC_AUX_MST_EN];

  // open-drain style: drive low only; pass-through follows primary lines
  always_comb begin
    if (userCtrl_reg[UPC_UC_AUX_MST_EN]) begin
      auxDataOut  = 1'b0;
      auxDataOe   = !mstSdaOut;
      auxClockOut = 1'b0;
      auxClockOe  = !mstSclOut;
    end else begin
      auxDataOut  = 1'b0;
      auxDataOe   = !priSdaIn;
      auxClockOut = 1'b0;
      auxClockOe  = !priSclIn;
    end
  end

  // read data registered, reserved bits zero, unmapped reads zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        UPC_OFS_USER_CONTROL: regRdata <= userCtrl_reg;
        UPC_OFS_POWER_ONE:    regRdata <= {softReset, powerOne_reg[6:0]};
        UPC_OFS_POWER_TWO:    regRdata <= powerTwo_reg;
        default:              regRdata <= 8'h00;
      endcase
    end
  end

endmodule : upc_regs

/* File: upc_regs_monitor.sv */
// assertion checker for the user and power control bank
`timescale 1ns/1ps
module upc_regs_monitor
  import upc_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic [7:0] regWdata,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  // sample queue
  input wire logic       queuePushReq,
  input wire logic       queuePopReq,
  input wire logic       queuePushOk,
  input wire logic       queuePopOk,
  input wire logic       queueReinit,
  // auxiliary bus
  input wire logic       priSdaIn,
  input wire logic       priSclIn,
  input wire logic       mstSdaOut,
  input wire logic       mstSclOut,
  input wire logic       auxMasterActive,
  input wire logic       auxMasterReinit,
  input wire logic       auxDataOut,
  input wire logic       auxDataOe,
  input wire logic       auxClockOut,
  input wire logic       auxClockOe,
  // sensors, power and clock
  input wire logic       spiSelect,
  input wire logic       sensorPathReinit,
  input wire logic       sensorResultClear,
  input wire logic [2:0] accelStandby,
  input wire logic [2:0] gyroStandby,
  input wire logic       thermoOff,
  input wire logic       accelSampleReq,
  input wire logic       sleepMode,
  input wire logic       lowPowerAccelOnly,
  input wire logic       deviceReset,
  input wire logic [2:0] clockSourceSel,
  input wire logic       clockStopped
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // length of the running device reset; 20 fits easily in eight bits
  logic [7:0] rstRun_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstRun_reg <= 8'h00;
    end else if (deviceReset) begin
      rstRun_reg <= rstRun_reg + 8'h01;
    end else begin
      rstRun_reg <= 8'h00;
    end
  end

  sequence sensorWr;
    regWrite && regAddr == UPC_OFS_USER_CONTROL && regWdata[UPC_UC_SENSOR_RST];
  endsequence
  sequence devRstWr;
    regWrite && regAddr == UPC_OFS_POWER_ONE && regWdata[UPC_P1_DEV_RESET];
  endsequence

  sensor_pulse_a: assert property (sensorWr |=> sensorPathReinit && sensorResultClear)
    else $error("sensor path reset did not pulse");
  dev_reset_start_a: assert property (devRstWr |=> deviceReset)
    else $error("device reset did not start");
  dev_reset_len_a: assert property ($fell(deviceReset) |-> rstRun_reg == 8'h14)
    else $error("device reset length wrong");
  aux_route_a: assert property (!auxMasterActive |-> auxDataOe == !priSdaIn
    && auxClockOe == !priSclIn && !auxDataOut && !auxClockOut)
    else $error("aux lines not following primary bus");
  aux_master_a: assert property (auxMasterActive |-> auxDataOe == !mstSdaOut
    && auxClockOe == !mstSclOut)
    else $error("aux lines not following master engine");
  aux_reinit_a: assert property (auxMasterReinit |-> $past(!auxMasterActive))
    else $error("aux master reset while enabled");
  queue_refuse_a: assert property (queueReinit |-> !queuePushOk && !queuePopOk)
    else $error("queue access granted while disabled");
  low_power_a: assert property (lowPowerAccelOnly |-> sleepMode && thermoOff
    && gyroStandby == 3'h7)
    else $error("accel-only mode without its conditions");
  wake_sample_a: assert property (accelSampleReq |-> sleepMode ##1 !accelSampleReq)
    else $error("wake sample outside cycle mode or too long");
  clk_stop_a: assert property (clockStopped == (clockSourceSel == 3'h7))
    else $error("clock stop flag disagrees with code");
  clk_fallback_a: assert property (clockSourceSel inside {3'h1, 3'h2, 3'h3}
    |-> ($past(gyroStandby) & (3'h4 >> (clockSourceSel - 3'h1))) == 3'h0)
    else $error("gyro clock kept while its axis idles");
endmodule : upc_regs_monitor

bind upc_regs upc_regs_monitor mon_u (.*);

/* File: upc_host_model.sv */
// host processor model on the register port
`timescale 1ns/1ps
module upc_host_model (
  // clock
  input  wire logic       clk_sys,
  // register port
  output logic [7:0]      regAddr,
  output logic            regWrite,
  output logic [7:0]      regWdata,
  output logic            regRead,
  input  wire logic [7:0] regRdata
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWdata = 8'h00;
    regRead = 1'b0;
  end

  // idle address and data are inverted so a stale value never looks live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask : rd
endmodule : upc_host_model

/* File: upc_regs_tb.sv */
// self-checking bench for the user and power control bank
`timescale 1ns/1ps
module upc_regs_tb
  import upc_pkg::*;
;
  // short wake periods keep the run brief
  localparam int WK [4] = '{20, 10, 6, 4};
  localparam logic [7:0] PRE [6] = '{8'h00, 8'h40, 8'h00, 8'h20, 8'h00, 8'h60};
  localparam logic [7:0] BIT [6] = '{8'h04, 8'h04, 8'h02, 8'h02, 8'h01, 8'h01};
  localparam logic [2:0] RX [6] = '{3'h4, 3'h0, 3'h2, 3'h0, 3'h1, 3'h1};
  localparam logic [7:0] SB [3] = '{8'h3A, 8'h25, 8'h00};
  localparam logic [15:0] SX [3] = '{16'h003A, 16'h00A5, 16'h0080};

  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] regAddr, regWdata, regRdata;
  logic       regWrite, regRead, queuePushReq, queuePopReq, queuePushOk, queuePopOk;
  logic       queueReinit, priSdaIn, priSclIn, mstSdaOut, mstSclOut, auxMasterActive;
  logic       auxMasterReinit, auxDataOut, auxDataOe, auxClockOut, auxClockOe, spiSelect;
  logic       sensorPathReinit, sensorResultClear, thermoOff, accelSampleReq, sleepMode;
  logic       lowPowerAccelOnly, deviceReset, clockStopped;
  logic [2:0] accelStandby, gyroStandby, clockSourceSel;
  int         err_total = 0;
  int         checks_done = 0;
  int         i;
  int         n;

  upc_regs #(.WAKE_CYCLES_0(WK[0]), .WAKE_CYCLES_1(WK[1]), .WAKE_CYCLES_2(WK[2]),
    .WAKE_CYCLES_3(WK[3])) dut_u (.*);
  upc_host_model host_u (.*);

  always #2.5 clk_sys = ~clk_sys;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(16'(d), 16'(exp));
  endtask : rchk

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic setIn(input logic [5:0] v);
    @(posedge clk_sys);
    {queuePushReq, queuePopReq, priSdaIn, priSclIn, mstSdaOut, mstSclOut} <= v;
  endtask : setIn

  // bounded wait for a wake pulse, then cycles to the next one
  task automatic period(output int p);
    int k;
    for (k = 0; k < 100 && accelSampleReq !== 1'b1; k++) tick(1);
    p = 0;
    do begin
      tick(1);
      p++;
    end while (accelSampleReq !== 1'b1 && p < 100);
  endtask : period

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    {queuePushReq, queuePopReq, priSdaIn, priSclIn, mstSdaOut, mstSclOut} = 6'h0F;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    tick(1);
    chk(16'(clockSourceSel), 16'h0000);
    rchk(UPC_OFS_USER_CONTROL, UPC_UC_RESET);
    rchk(UPC_OFS_POWER_ONE, UPC_P1_RESET);
    rchk(UPC_OFS_POWER_TWO, UPC_P2_RESET);
    host_u.wr(8'h6D, 8'hFF);
    rchk(8'h6D, 8'h00);
    host_u.wr(UPC_OFS_USER_CONTROL, 8'hFF);
    rchk(UPC_OFS_USER_CONTROL, 8'h70);
    setIn(6'h3D);
    tick(1);
    chk(16'({queuePushOk, queuePopOk, auxMasterActive, spiSelect, auxDataOe, auxClockOe}),
      16'h003E);
    host_u.wr(UPC_OFS_USER_CONTROL, 8'h00);
    setIn(6'h36);
    tick(1);
    chk(16'({queuePushOk, queuePopOk, auxMasterActive, spiSelect, auxDataOe, auxClockOe}),
      16'h0002);
    // an enabled unit must ignore its reset request
    for (i = 0; i < 6; i++) begin
      host_u.wr(UPC_OFS_USER_CONTROL, PRE[i]);
      host_u.wr(UPC_OFS_USER_CONTROL, PRE[i] | BIT[i]);
      #1;
      chk(16'({queueReinit, auxMasterReinit, sensorPathReinit}), 16'(RX[i]));
      tick(1);
      chk(16'({queueReinit, auxMasterReinit, sensorPathReinit}), 16'h0000);
      rchk(UPC_OFS_USER_CONTROL, PRE[i]);
    end
    host_u.wr(UPC_OFS_POWER_ONE, 8'h7F);
    rchk(UPC_OFS_POWER_ONE, 8'h6F);
    chk(16'({sleepMode, thermoOff, clockStopped}), 16'h0007);
    for (i = 0; i < 8; i++) begin
      host_u.wr(UPC_OFS_POWER_ONE, 8'(i));
      tick(2);
      chk(16'({sleepMode, thermoOff, clockStopped, clockSourceSel}),
        16'(i) | (i == 7 ? 16'h0008 : 16'h0000));
    end
    host_u.wr(UPC_OFS_POWER_ONE, 8'h02);
    for (i = 0; i < 3; i++) begin
      host_u.wr(UPC_OFS_POWER_TWO, SB[i]);
      rchk(UPC_OFS_POWER_TWO, SB[i]);
      chk(16'({clockSourceSel, accelStandby, gyroStandby}), SX[i]);
    end
    rchk(UPC_OFS_POWER_ONE, 8'h02);
    host_u.wr(UPC_OFS_POWER_ONE, 8'h28);
    for (i = 0; i < 4; i++) begin
      host_u.wr(UPC_OFS_POWER_TWO, 8'(i << 6) | 8'h07);
      rchk(UPC_OFS_POWER_TWO, 8'(i << 6) | 8'h07);
      chk(16'({lowPowerAccelOnly, sleepMode}), 16'h0003);
      period(n);
      period(n);
      chk(16'(n), 16'(WK[i]));
    end
    host_u.wr(UPC_OFS_POWER_ONE, 8'h80);
    #1;
    n = 0;
    while (deviceReset === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk(16'(n), 16'(UPC_DEV_RESET_CYCLES));
    rchk(UPC_OFS_USER_CONTROL, UPC_UC_RESET);
    rchk(UPC_OFS_POWER_ONE, UPC_P1_RESET);
    rchk(UPC_OFS_POWER_TWO, UPC_P2_RESET);
    end_of_test();
  end

  // whole run is near 300 cycles; a hang is cut well past that
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end
endmodule : upc_regs_tb
